/* File: verilog/rjl_pkg.sv */
// Shared constants and types for the register jump and load executor.
package rjl_pkg;
   // Width of general registers.
   localparam int XLEN             = 64;
   // Width of the memory bus.
   localparam int BUS_W            = 128;
   // Width of a physical address.
   localparam int PA_W             = 32;
   // Link offset past the jump.
   localparam logic [31:0] LINK_OFS = 32'h0000_0008;
   // Default link register number.
   localparam logic [4:0]  LINK_DEF = 5'h1F;
   // Access sizes sent to memory.
   localparam logic [1:0]  SZ_BYTE  = 2'h0;
   localparam logic [1:0]  SZ_DWORD = 2'h3;
   // Reset value of the program counter.
   localparam logic [31:0] PC_RST   = 32'h0000_0000;

   // Operations this block executes.
   typedef enum logic [2:0] {
      RJL_NOP  = 3'h0,
      RJL_JR   = 3'h1,
      RJL_JUMP_LINK_VIA_REGISTER = 3'h2,
      RJL_LB   = 3'h3,
      RJL_LBU  = 3'h4,
      RJL_LD   = 3'h5
   } rjl_op_e;

   // Load sequencer states, Gray coded.
   typedef enum logic [1:0] {
      RJL_IDLE = 2'b00,
      RJL_XLAT = 2'b01,
      RJL_MEM  = 2'b11
   } rjl_state_e;
endpackage : rjl_pkg

/* File: verilog/rjl_lane.sv */
// Byte and doubleword lane selection and extension for loads.
module rjl_lane
   import rjl_pkg::*;
(
   input  wire logic [BUS_W-1:0] i_quad,     // Returned memory quadword.
   input  wire logic [3:0]       i_vlow,     // Low virtual address bits.
   input  wire logic             i_endian,   // Endian flag.
   input  wire rjl_op_e          i_op,       // Load operation.
   output logic [XLEN-1:0]       o_value     // Value for target register.
);
   logic [3:0] lane;   // Byte lane after endian fold.
   logic       half;   // Doubleword half after endian fold.
   logic [7:0] b;      // Selected byte.

   // Select the lane and extend it as the operation asks.
   always_comb begin
      lane = i_vlow ^ {4{i_endian}};
      half = i_vlow[3] ^ i_endian;
      b    = i_quad[8*lane +: 8];
      case (i_op)
         RJL_LB:  o_value = {{(XLEN-8){b[7]}}, b};
         RJL_LBU: o_value = {{(XLEN-8){1'b0}}, b};
         RJL_LD:  o_value = half ? i_quad[127:64] : i_quad[63:0];
         default: o_value = '0;
      endcase
   end
endmodule : rjl_lane

/* File: verilog/rjl_exec.sv */
// Executor for register jumps and byte/doubleword loads.
module rjl_exec
   import rjl_pkg::*;
(
   input  wire logic             i_clk,        // Core clock.
   input  wire logic             i_nrst,       // Synchronous reset, low.
   input  wire logic             i_valid,      // Instruction offered.
   input  wire rjl_op_e          i_op,         // Decoded operation.
   input  wire logic [31:0]      i_pc,         // Instruction address.
   input  wire logic [XLEN-1:0]  i_src,        // Source or base value.
   input  wire logic [15:0]      i_offset,     // Load offset.
   input  wire logic [4:0]       i_dest,       // Link or target register.
   input  wire logic             i_dest_coded, // Link register was coded.
   input  wire logic             i_slot_fault, // Delay slot raised fault.
   input  wire logic             i_endian,     // Endian flag.
   input  wire logic             i_fetch_req,  // Fetch unit fetches PC.
   input  wire logic             i_xlat_done,  // Translation finished.
   input  wire logic [PA_W-1:0]  i_xlat_pa,    // Physical address.
   input  wire logic             i_xlat_unc,   // Uncached attribute.
   input  wire logic             i_mem_done,   // Memory data returned.
   input  wire logic [BUS_W-1:0] i_mem_data,   // Returned quadword.
   output logic                  o_busy,       // Load in progress.
   output logic                  o_pc_load,    // Program counter loaded.
   output logic [31:0]           o_pc,         // New program counter.
   output logic                  o_fetch_aerr, // Fetch address error.
   output logic                  o_xlat_req,   // Translation request.
   output logic [31:0]           o_xlat_va,    // Virtual address out.
   output logic                  o_mem_req,    // Memory request.
   output logic [PA_W-1:0]       o_mem_pa,     // Folded physical address.
   output logic [1:0]            o_mem_size,   // Access size.
   output logic                  o_mem_unc,    // Uncached access.
   output logic                  o_load_aerr,  // Load address error.
   output logic                  o_wr_en,      // Register write strobe.
   output logic [4:0]            o_wr_idx,     // Register written.
   output logic [XLEN-1:0]       o_wr_data,    // Register write data.
   output logic                  o_restart_vld,// Restart address valid.
   output logic [31:0]           o_restart_pc  // Restart address.
);
   import rjl_pkg::*;

   // Whole state of the executor.
   typedef struct packed {
      rjl_state_e       st;          // Load sequencer state.
      logic             pend;        // Jump waits for its delay slot.
      logic [31:0]      target;      // Captured jump target.
      logic [31:0]      jump_pc;     // Address of pending jump.
      rjl_op_e          lop;         // Load in flight.
      logic [4:0]       lreg;        // Load target register.
      logic [3:0]       vlow;        // Low virtual address bits.
      logic             pc_load;     // Output copies follow.
      logic [31:0]      pc;
      logic             fetch_aerr;
      logic             aligned;     // Last loaded target aligned, or its fetch fault already raised.
      logic             xlat_req;
      logic [31:0]      va;
      logic             mem_req;
      logic [PA_W-1:0]  pa;
      logic [1:0]       size;
      logic             unc;
      logic             load_aerr;
      logic             wr_en;
      logic [4:0]       wr_idx;
      logic [XLEN-1:0]  wr_data;
      logic             rst_vld;
      logic [31:0]      rst_pc;
      logic             busy;        // Load in flight.
   } rjl_state_s;

   rjl_state_s state_reg;   // Registered state.
   rjl_state_s state_next;  // Next state.
   logic [XLEN-1:0] lane_value;  // Extended load value.
   logic [31:0]     ea;          // Effective address of an offered load.

   // Effective address: sign-extended offset plus low base word.
   function automatic logic [31:0] eff_addr(input logic [31:0] base,
                                            input logic [15:0] ofs);
      eff_addr = base + {{16{ofs[15]}}, ofs};
   endfunction : eff_addr

   // Lane selection and extension of returned data.
   rjl_lane u_lane (
      .i_quad   (i_mem_data),
      .i_vlow   (state_reg.vlow),
      .i_endian (i_endian),
      .i_op     (state_reg.lop),
      .o_value  (lane_value)
   );

   assign ea = eff_addr(i_src[31:0], i_offset);

   // Next-state logic for jumps and the load sequencer.
   always_comb begin
      state_next            = state_reg;
      state_next.pc_load    = 1'b0;
      state_next.fetch_aerr = 1'b0;
      state_next.load_aerr  = 1'b0;
      state_next.wr_en      = 1'b0;
      state_next.xlat_req   = 1'b0;
      state_next.mem_req    = 1'b0;
      state_next.rst_vld    = 1'b0;
      // A target fetched while misaligned raises its error now.
      if (i_fetch_req && !state_reg.aligned) begin
         state_next.fetch_aerr = 1'b1;
         state_next.aligned    = 1'b1;
      end
      if (state_reg.pend && i_valid) begin
         // Delay slot instruction is offered now; transfer follows it.
         state_next.pend = 1'b0;
         if (i_slot_fault) begin
            // Restart at the jump so the handler re-executes it.
            state_next.rst_vld = 1'b1;
            state_next.rst_pc  = state_reg.jump_pc;
         end else begin
            state_next.pc_load = 1'b1;
            state_next.pc      = state_reg.target;
            state_next.aligned = (state_reg.target[1:0] == 2'h0);
         end
      end
      case (state_reg.st)
         RJL_IDLE: begin
            if (i_valid && (i_op == RJL_JR || i_op == RJL_JUMP_LINK_VIA_REGISTER)) begin
               // Capture target now, load it after the slot.
               state_next.pend    = 1'b1;
               state_next.target  = i_src[31:0];
               state_next.jump_pc = i_pc;
               if (i_op == RJL_JUMP_LINK_VIA_REGISTER) begin
                  // Source equal to destination is left undefined.
                  state_next.wr_en   = 1'b1;
                  state_next.wr_idx  = i_dest_coded ? i_dest
                                                    : LINK_DEF;
                  state_next.wr_data = {32'h0000_0000,
                                        i_pc + LINK_OFS};
               end
            end else if (i_valid && (i_op == RJL_LB || i_op == RJL_LBU ||
                                     i_op == RJL_LD)) begin
               state_next.lop  = i_op;
               state_next.lreg = i_dest;
               state_next.vlow = ea[3:0];
               state_next.va   = ea;
               if (i_op == RJL_LD && ea[2:0] != 3'h0) begin
                  // Misaligned doubleword stops before translation.
                  state_next.load_aerr = 1'b1;
               end else begin
                  state_next.xlat_req = 1'b1;
                  state_next.st       = RJL_XLAT;
               end
            end
         end
         RJL_XLAT: begin
            state_next.xlat_req = !i_xlat_done;
            if (i_xlat_done) begin
               // Fold low address bits by the endian flag.
               if (state_reg.lop == RJL_LD) begin
                  state_next.pa   = {i_xlat_pa[PA_W-1:4],
                     i_xlat_pa[3:0] ^ {i_endian, 3'h0}};
                  state_next.size = SZ_DWORD;
               end else begin
                  state_next.pa   = {i_xlat_pa[PA_W-1:4],
                     i_xlat_pa[3:0] ^ {4{i_endian}}};
                  state_next.size = SZ_BYTE;
               end
               state_next.unc     = i_xlat_unc;
               state_next.mem_req = 1'b1;
               state_next.st      = RJL_MEM;
            end
         end
         RJL_MEM: begin
            state_next.mem_req = !i_mem_done;
            if (i_mem_done) begin
               state_next.wr_en   = 1'b1;
               state_next.wr_idx  = state_reg.lreg;
               state_next.wr_data = lane_value;
               state_next.st      = RJL_IDLE;
            end
         end
         default: state_next.st = RJL_IDLE;
      endcase
      // Busy follows the sequencer so that the port comes from a flop.
      state_next.busy = (state_next.st != RJL_IDLE);
   end

   // State register with synchronous reset.
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_reg         <= '0;
         state_reg.st      <= RJL_IDLE;
         state_reg.lop     <= RJL_NOP;
         state_reg.pc      <= PC_RST;
         state_reg.aligned <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_busy        = state_reg.busy;
   assign o_pc_load     = state_reg.pc_load;
   assign o_pc          = state_reg.pc;
   assign o_fetch_aerr  = state_reg.fetch_aerr;
   assign o_xlat_req    = state_reg.xlat_req;
   assign o_xlat_va     = state_reg.va;
   assign o_mem_req     = state_reg.mem_req;
   assign o_mem_pa      = state_reg.pa;
   assign o_mem_size    = state_reg.size;
   assign o_mem_unc     = state_reg.unc;
   assign o_load_aerr   = state_reg.load_aerr;
   assign o_wr_en       = state_reg.wr_en;
   assign o_wr_idx      = state_reg.wr_idx;
   assign o_wr_data     = state_reg.wr_data;
   assign o_restart_vld = state_reg.rst_vld;
   assign o_restart_pc  = state_reg.rst_pc;

   // Link value is PC plus eight with upper word zero.
   a_link_value: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_valid && i_op == RJL_JUMP_LINK_VIA_REGISTER && state_reg.st == RJL_IDLE) |=>
      (o_wr_en && o_wr_data == {32'h0, $past(i_pc) + 32'h8}))
      else $error("link value wrong");
   // Uncoded link destination goes to register 31.
   a_link_default: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_valid && i_op == RJL_JUMP_LINK_VIA_REGISTER && !i_dest_coded &&
       state_reg.st == RJL_IDLE) |=> (o_wr_idx == 5'h1F))
      else $error("link register wrong");
   // Transfer waits for the delay slot.
   a_slot_first: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      o_pc_load |-> $past(state_reg.pend && i_valid))
      else $error("transfer before slot");
   // Loaded PC equals captured target.
   a_target_pc: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      o_pc_load |-> o_pc == $past(state_reg.target))
      else $error("target wrong");
   // Misaligned target faults only at fetch.
   a_fetch_fault: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (o_pc_load && o_pc[1:0] != 2'h0 && !i_fetch_req) |=> !o_fetch_aerr)
      else $error("fault before fetch");
   // Address sent for translation matches the effective address of a signed byte load.
   a_xlat_addr: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_valid && state_reg.st == RJL_IDLE && i_op == RJL_LB) |=>
      (o_xlat_req && o_xlat_va == $past(ea)))
      else $error("address wrong");
   // Misaligned doubleword never translates.
   a_ld_align: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (i_valid && state_reg.st == RJL_IDLE && i_op == RJL_LD &&
       ea[2:0] != 3'h0) |=> (o_load_aerr && !o_xlat_req))
      else $error("misaligned load went on");
   // Memory request follows translation.
   a_mem_after: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_mem_req) |-> $past(i_xlat_done))
      else $error("memory before translation");
   // Delay slot fault gives the jump address and suppresses the transfer.
   a_restart_pc: assert property (
      @(posedge i_clk) disable iff (!i_nrst)
      (state_reg.pend && i_valid && i_slot_fault) |=>
      (o_restart_vld && !o_pc_load &&
       o_restart_pc == $past(state_reg.jump_pc)))
      else $error("restart wrong");
endmodule : rjl_exec

/* File: tb/rjl_mem_model.sv */
// Translation and memory responder standing behind the executor.
module rjl_mem_model
   import rjl_pkg::*;
(
   input  wire logic             i_clk,       // Core clock.
   input  wire logic [3:0]       i_dly,       // Answer delay in cycles.
   input  wire logic             i_xlat_req,  // Translation request.
   input  wire logic [31:0]      i_xlat_va,   // Virtual address.
   input  wire logic             i_mem_req,   // Memory request.
   output logic                  o_xlat_done, // Translation answer.
   output logic [PA_W-1:0]       o_xlat_pa,   // Physical address.
   output logic                  o_xlat_unc,  // Uncached attribute.
   output logic                  o_mem_done,  // Memory answer.
   output logic [BUS_W-1:0]      o_mem_data   // Returned quadword.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]       cnt = 4'h0; // Cycles waited on the open request.
   logic [BUS_W-1:0] quad; // Fixed memory image, byte k is {k, ~k}.

   // Builds the memory image once.
   initial begin
      for (int k = 0; k < 16; k++) begin
         quad[8*k+:8] = {k[3:0], ~k[3:0]};
      end
   end

   // Answers each request once after the set delay; stale data is inverted.
   always @(posedge i_clk) begin
      o_xlat_done <= 1'b0;
      o_mem_done <= 1'b0;
      o_xlat_pa <= ~o_xlat_pa;
      o_mem_data <= ~o_mem_data;
      if (!(i_xlat_req || i_mem_req) || o_xlat_done || o_mem_done) begin
         cnt <= 4'h0;
      end else if (cnt != i_dly) begin
         cnt <= cnt + 4'h1;
      end else if (i_xlat_req) begin
         cnt <= 4'h0;
         o_xlat_done <= 1'b1;
         o_xlat_pa <= i_xlat_va;
         o_xlat_unc <= i_xlat_va[20];
      end else begin
         cnt <= 4'h0;
         o_mem_done <= 1'b1;
         o_mem_data <= quad;
      end
   end
endmodule : rjl_mem_model

/* File: tb/register_jump_and_load_exec_tb.sv */
// Self-checking bench for the register jump and load executor.
module register_jump_and_load_exec_tb import rjl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      rjl_op_e op; logic [63:0] base; logic [15:0] ofs; logic e;
      logic [63:0] exp;
   } rjl_row_s;
   localparam int EW = 0, EM = 1, ER = 5, EF = 6;
   logic i_clk = 1'b0, i_nrst = 1'b0, i_valid = 1'b0, i_dest_coded = 1'b0;
   logic i_slot_fault = 1'b0, i_endian = 1'b0, i_fetch_req = 1'b0;
   rjl_op_e i_op = RJL_NOP;
   logic [31:0] i_pc = 32'h0, o_pc, o_xlat_va, o_restart_pc;
   logic [XLEN-1:0] i_src = '0, o_wr_data;
   logic [15:0] i_offset = 16'h0;
   logic [4:0] i_dest = 5'h0, o_wr_idx;
   logic [3:0] dly = 4'h0;
   logic i_xlat_done, i_xlat_unc, i_mem_done, o_busy, o_pc_load;
   logic o_fetch_aerr, o_xlat_req, o_mem_req, o_mem_unc, o_load_aerr;
   logic o_wr_en, o_restart_vld;
   logic [PA_W-1:0] i_xlat_pa, o_mem_pa;
   logic [BUS_W-1:0] i_mem_data;
   logic [1:0] o_mem_size;
   int bad_count = 0, num_checks = 0;
   wire [6:0] ev = {o_fetch_aerr, o_restart_vld, o_load_aerr, o_pc_load,
                    o_xlat_req, o_mem_req, o_wr_en};
   rjl_row_s rows [9] = '{
      '{RJL_LB, 64'h0010_1000, 16'h0003, 1'b0, 64'h3C},
      '{RJL_LB, 64'hABCD_0000_0000_1000, 16'hFFF9, 1'b0, ~64'h69},
      '{RJL_LBU, 64'hABCD_0000_0000_1000, 16'hFFF9, 1'b0, 64'h96},
      '{RJL_LB, 64'h1000, 16'h0003, 1'b1, ~64'h3C},
      '{RJL_LBU, 64'h1000, 16'h000E, 1'b1, 64'h1E},
      '{RJL_LBU, 64'h1_0000, 16'h8000, 1'b0, 64'h0F},
      '{RJL_LD, 64'h2000, 16'h0008, 1'b0, 64'hF0E1_D2C3_B4A5_9687},
      '{RJL_LD, 64'h2000, 16'h0008, 1'b1, 64'h7869_5A4B_3C2D_1E0F},
      '{RJL_LD, 64'h2000, 16'h0004, 1'b0, 64'h0}};

   rjl_exec dut_u (.i_clk, .i_nrst, .i_valid, .i_op, .i_pc, .i_src,
      .i_offset, .i_dest, .i_dest_coded, .i_slot_fault, .i_endian,
      .i_fetch_req, .i_xlat_done, .i_xlat_pa, .i_xlat_unc, .i_mem_done,
      .i_mem_data, .o_busy, .o_pc_load, .o_pc, .o_fetch_aerr, .o_xlat_req,
      .o_xlat_va, .o_mem_req, .o_mem_pa, .o_mem_size, .o_mem_unc,
      .o_load_aerr, .o_wr_en, .o_wr_idx, .o_wr_data, .o_restart_vld,
      .o_restart_pc);
   rjl_mem_model mem_u (.i_clk, .i_dly(dly), .i_xlat_req(o_xlat_req),
      .i_xlat_va(o_xlat_va), .i_mem_req(o_mem_req), .o_xlat_done(i_xlat_done),
      .o_xlat_pa(i_xlat_pa), .o_xlat_unc(i_xlat_unc),
      .o_mem_done(i_mem_done), .o_mem_data(i_mem_data));

   // Clock of 100 ns period.
   always #50 i_clk = ~i_clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   // Compares a seen value with the expected one.
   task automatic check(input string nm, input logic [63:0] s, e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      end
   endtask : check

   // Waits, bounded, for one output event.
   task automatic wait_ev(input int k);
      int n;
      n = 0;
      while (ev[k] !== 1'b1) begin
         @(negedge i_clk);
         n++;
         if (n > 40) begin
            check("event wait", 1'b0, 1'b1);
            stop_test();
         end
      end
   endtask : wait_ev

   // Offers one instruction for a single cycle at the falling edge.
   // Callers let one edge pass before the next offer, except for the reset test load, which directly follows the slot fault offer.
   task automatic issue(input rjl_op_e op, input logic [31:0] pc,
                        input logic [63:0] src, input logic [4:0] dst);
      i_valid = 1'b1;
      i_op = op;
      i_pc = pc;
      i_src = src;
      i_dest = dst;
      @(negedge i_clk);
      i_valid = 1'b0;
   endtask : issue

   // Runs one load row, with a refused offer while it is busy; a misaligned doubleword row stops at its error with no such offer.
   task automatic run_load(input int r);
      logic [31:0] va;
      logic        bt;
      va = rows[r].base[31:0] + {{16{rows[r].ofs[15]}}, rows[r].ofs};
      bt = (rows[r].op != RJL_LD);
      i_endian = rows[r].e;
      i_offset = rows[r].ofs;
      dly = r[3:0];
      issue(rows[r].op, 32'h0, rows[r].base, 5'(r + 1));
      if (!bt && va[2:0] != 3'h0) begin
         check("load_aerr", o_load_aerr, 1'b1);
         check("xlat_req", o_xlat_req, 1'b0);
         @(negedge i_clk);
         return;
      end
      check("xlat_va", o_xlat_va, va);
      @(negedge i_clk);
      issue(RJL_LBU, 32'h0, 64'h0, 5'h1D);
      wait_ev(EM);
      check("mem_pa", o_mem_pa, {va[31:4], va[3:0] ^ (bt ?
            {4{rows[r].e}} : {rows[r].e, 3'b000})});
      check("mem_size", o_mem_size, bt ? SZ_BYTE : SZ_DWORD);
      check("mem_unc", o_mem_unc, va[20]);
      wait_ev(EW);
      check("wr_idx", o_wr_idx, 5'(r + 1));
      check("wr_data", o_wr_data, rows[r].exp);
      check("busy", o_busy, 1'b0);
      @(negedge i_clk);
      check("refused", o_xlat_req, 1'b0);
   endtask : run_load

   // Main sequence: reset, load rows, then jumps, faults and reset again.
   initial begin
      repeat (3) @(negedge i_clk);
      i_nrst = 1'b1;
      check("reset busy", o_busy, 1'b0);
      check("reset pc", o_pc, 32'h0);
      for (int r = 0; r < 9; r++) begin
         run_load(r);
         $display("Load row %0d done", r);
      end
      // Source and link registers are always kept distinct.
      i_dest_coded = 1'b1;
      issue(RJL_JUMP_LINK_VIA_REGISTER, 32'h100, 64'hFFFF_FFFF_0000_0400, 5'h05);
      check("link_en", o_wr_en, 1'b1);
      check("link_idx", o_wr_idx, 5'h05);
      check("link_data", o_wr_data, 64'h108);
      repeat (2) @(negedge i_clk);
      check("pc_early", o_pc_load, 1'b0);
      issue(RJL_NOP, 32'h104, 64'h0, 5'h0);
      check("pc_load", o_pc_load, 1'b1);
      check("pc", o_pc, 32'h400);
      i_fetch_req = 1'b1;
      @(negedge i_clk);
      i_fetch_req = 1'b0;
      check("aligned fetch", o_fetch_aerr, 1'b0);
      i_dest_coded = 1'b0;
      issue(RJL_JUMP_LINK_VIA_REGISTER, 32'h8000_0000, 64'h402, 5'h07);
      check("link_idx", o_wr_idx, LINK_DEF);
      check("link_data", o_wr_data, 64'h8000_0008);
      @(negedge i_clk);
      issue(RJL_NOP, 32'h8000_0004, 64'h0, 5'h0);
      check("pc", o_pc, 32'h402);
      check("jump fault", o_fetch_aerr, 1'b0);
      i_fetch_req = 1'b1;
      @(negedge i_clk);
      i_fetch_req = 1'b0;
      wait_ev(EF);
      check("fetch fault", o_fetch_aerr, 1'b1);
      @(negedge i_clk);
      check("fault once", o_fetch_aerr, 1'b0);
      $display("Jump tests done");
      issue(RJL_JR, 32'h200, 64'h300, 5'h0);
      check("jr write", o_wr_en, 1'b0);
      @(negedge i_clk);
      i_slot_fault = 1'b1;
      issue(RJL_NOP, 32'h204, 64'h0, 5'h0);
      i_slot_fault = 1'b0;
      wait_ev(ER);
      check("restart_pc", o_restart_pc, 32'h200);
      check("no pc load", o_pc_load, 1'b0);
      $display("Slot fault test done");
      dly = 4'h8;
      issue(RJL_LB, 32'h0, 64'h1000, 5'h02);
      i_nrst = 1'b0;
      @(negedge i_clk);
      i_nrst = 1'b1;
      check("reset busy", o_busy, 1'b0);
      check("reset xlat", o_xlat_req, 1'b0);
      $display("Reset test done");
      stop_test();
   end
endmodule : register_jump_and_load_exec_tb
